//--- dv/testbench.sv
// self-checking bench for tx_port_regs
// assumes the register header is on the include path
`timescale 1ns/1ps
`include "tx_port_regs_consts.vh"
module testbench;
  localparam [7:0] ctl = `ADDR_TX_PORT_CONTROL_TWO, sts = `ADDR_TX_PORT_STATUS;
  localparam [7:0] ien = `ADDR_TX_INTERRUPT_ENABLE, isr = `ADDR_TX_INTERRUPT_STATUS;
  reg core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, tx_write_port = 1, tx_read_port = 0;
  reg sync_forwarding_enabled = 0, async_forwarding = 0, tx_error = 0, streams_synced = 0;
  reg sync_fault = 0, rx_port_irq = 0, link_idle = 0, frame_end = 0;
  reg [7:0] reg_addr = 0, reg_wdata = 0;
  reg [3:0] rx_port_enabled = 0, rx_port_valid = 0;
  wire [7:0] reg_rdata_q;
  wire cal_active_q, cal_bit_q, irq_q;
  integer err_count = 0, n_tests = 0, cyc = 0, i;
  always #2.5 core_clk = ~core_clk;
  tx_port_regs dut (.core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .tx_write_port, .tx_read_port, .sync_forwarding_enabled, .async_forwarding,
    .rx_port_enabled, .rx_port_valid, .tx_error, .streams_synced, .sync_fault, .rx_port_irq,
    .link_idle, .frame_end, .reg_rdata_q, .cal_active_q, .cal_bit_q, .irq_q);
  // -------------
  // bus and check
  // -------------
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      @(negedge core_clk) reg_wr = 0;
      @(negedge core_clk);
    end
  endtask
  task rdm(input [7:0] a, input [7:0] m, input [7:0] e);
    begin
      reg_addr = a;
      reg_rd = 1;
      @(negedge core_clk) reg_rd = 0;
      @(negedge core_clk) chk(reg_rdata_q & m, e);
    end
  endtask
  task w(input integer n);
    repeat (n) @(negedge core_clk);
  endtask
  task cal_run(input [15:0] n);
    begin
      for (i = 0; cal_active_q !== 1'b1 && i < 40; i = i + 1) w(1);
      for (i = 0; cal_active_q === 1'b1 && i < 1100; i = i + 1) begin
        chk(cal_bit_q, i[0]);
        w(1);
      end
      chk(i, n);
    end
  endtask
  // ---------
  // scenarios
  // ---------
  task t_regs;
    begin
      rdm(ctl, 8'hff, `CTL2_RESET);
      rdm(ien, 8'hff, `IE_RESET);
      wr(ien, 8'h1c);
      tx_write_port = 0;
      wr(ien, 8'h00);
      tx_write_port = 1;
      wr(sts, 8'hff);
      rdm(ien, 8'hff, 8'h1c);
      rdm(sts, 8'hff, 8'h00);
      rdm(8'h40, 8'hff, 8'h00);
      wr(ien, 8'h00);
    end
  endtask
  task t_sts;
    begin
      tx_read_port = 1;
      sync_forwarding_enabled = 1;
      streams_synced = 1;
      rx_port_enabled = 4'h3;
      rx_port_valid = 4'h1;
      w(5);
      rdm(sts, 8'hff, 8'h13);
      wr(ctl, 8'h08);
      w(3);
      rdm(sts, 8'hff, 8'h12);
      rx_port_valid = 4'h3;
      w(5);
      rdm(sts, 8'hff, 8'h13);
      sync_forwarding_enabled = 0;
      async_forwarding = 1;
      tx_error = 1;
      w(5);
      rdm(sts, 8'hff, 8'h10);
      tx_error = 0;
      async_forwarding = 0;
      wr(ctl, 8'h00);
    end
  endtask
  task t_irq;
    begin
      streams_synced = 0;
      sync_forwarding_enabled = 1;
      wr(ien, 8'h04);
      w(5);
      rdm(isr, 8'hff, 8'h00);
      w(2);
      chk(irq_q, 0);
      streams_synced = 1;
      w(6);
      chk(irq_q, 1);
      rdm(isr, 8'h04, 8'h04);
      w(2);
      chk(irq_q, 0);
      wr(ien, 8'h08);
      sync_fault = 1;
      w(6);
      chk(irq_q, 1);
      rdm(isr, 8'h08, 8'h08);
      sync_fault = 0;
      wr(ien, 8'h10);
      rx_port_irq = 1;
      w(6);
      chk(irq_q, 1);
      rx_port_irq = 0;
      w(6);
      chk(irq_q, 0);
      wr(ien, 8'h00);
    end
  endtask
  task t_cal;
    begin
      wr(ctl, 8'h02);
      w(8);
      chk(cal_active_q, 0);
      rdm(ctl, 8'hff, 8'h02);
      link_idle = 1;
      cal_run(16'h0400);
      rdm(ctl, 8'hff, 8'h00);
      wr(ctl, 8'h01);
      frame_end = 1;
      @(negedge core_clk) frame_end = 0;
      cal_run(16'h0400);
      wr(ctl, 8'h00);
      frame_end = 1;
      @(negedge core_clk) frame_end = 0;
      cal_run(16'h0000);
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      err_count = err_count + 1;
      results;
    end
  end
  initial begin
    w(2);
    rst_n = 1;
    w(1);
    t_regs;
    t_sts;
    t_irq;
    t_cal;
    results;
  end
endmodule // testbench

//--- dv/tx_port_regs_props.sv
// checker on the ports of tx_port_regs
// assumes the register header is on the include path
`timescale 1ns/1ps
`include "tx_port_regs_consts.vh"
module tx_port_regs_props (
  input wire core_clk,
  input wire rst_n,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire tx_read_port,
  input wire sync_forwarding_enabled,
  input wire [3:0] rx_port_valid,
  input wire link_idle,
  input wire [7:0] reg_rdata_q,
  input wire cal_active_q,
  input wire cal_bit_q
);
  // ----------
  // properties
  // ----------
  reg [10:0] len_q;
  wire sts_rd = reg_rd && reg_addr == `ADDR_TX_PORT_STATUS;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      len_q <= 11'h000;
    end else begin
      len_q <= cal_active_q ? len_q + 11'h001 : 11'h000;
    end
  end
  cal_len_a: assert property ($fell(cal_active_q) |-> len_q == 11'h400)
    else $error("bad calibration length");
  cal_toggle_a: assert property (cal_active_q && $past(cal_active_q) |->
    cal_bit_q != $past(cal_bit_q)) else $error("calibration bit stuck");
  cal_idle_a: assert property ($rose(cal_active_q) |-> $past(link_idle, 2) ||
    $past(link_idle, 3) || $past(link_idle, 4) || $past(link_idle, 5))
    else $error("calibration outside idle");
  sts_rsvd_a: assert property (sts_rd |=> reg_rdata_q[7:5] == 3'h0 &&
    reg_rdata_q[3:2] == 2'h0) else $error("status reserved bits set");
  port_num_a: assert property (tx_read_port[*5] ##0 sts_rd |=> reg_rdata_q[4])
    else $error("port number wrong");
  sync_off_a: assert property ((!sync_forwarding_enabled)[*5] ##0 sts_rd |=>
    !reg_rdata_q[1]) else $error("sync flag while disabled");
  pass_none_a: assert property ((rx_port_valid == 4'h0)[*5] ##0 sts_rd |=>
    !reg_rdata_q[0]) else $error("pass without valid port");
  rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata_q))
    else $error("read data changed");
endmodule // tx_port_regs_props
bind tx_port_regs tx_port_regs_props u_props (.core_clk, .rst_n, .reg_rd, .reg_addr,
  .tx_read_port, .sync_forwarding_enabled, .rx_port_valid, .link_idle, .reg_rdata_q,
  .cal_active_q, .cal_bit_q);

//--- hdl/skew_cal_seq.v
// skew-calibration bit sequencer: emits 2^10 alternating bits
// assumes a start pulse on core_clk, one bit per cycle
`timescale 1ns/1ps
`include "tx_port_regs_consts.vh"
module skew_cal_seq (
  input wire core_clk,
  input wire rst_n,
  input wire start,
  input wire invert,
  output reg busy_q,
  output reg cal_bit_q,
  output reg done_q
);
  reg [10:0] cnt_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q <= 11'h000;
      cal_bit_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!busy_q) begin
        // first bit of the pattern is launched with busy so both align
        if (start) begin
          busy_q <= 1'b1;
          cnt_q <= 11'h000;
          cal_bit_q <= invert;
        end else begin
          cal_bit_q <= 1'b0;
        end
      end else begin
        cal_bit_q <= ~cal_bit_q;
        if (cnt_q == `CAL_LEN_BITS - 11'h001) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
        cnt_q <= cnt_q + 11'h001;
      end
    end
  end
endmodule // skew_cal_seq

//--- hdl/tx_port_regs.v
// paged control, status and interrupt-enable slice of a transmit port
// assumes a byte register port on core_clk; status inputs are pins
// Function
// - single trigger sends one calibration of 2^10 bits.
// - single calibration waits for the interface to become idle.
// - single trigger bit clears itself after the sequence ends.
// - periodic enable sends calibration after every frame end.
// - status bit 4 shows the selected readback port number.
// - sync flag bit 1 reads 1 while streams are synchronized.
// - sync flag forced 0 when synchronization is disabled.
// - pass flag bit 0 shows valid data on one or all ports.
// - in asynchronous forwarding pass clears on transmission error.
// - in synchronized forwarding pass means data available.
// - enable bit 4 passes receive-port interrupts.
// - enable bit 3 gates synchronization-error interrupt.
// - enable bit 2 passes sync-achieved interrupt.
// - pass mode 0 needs any valid port, 1 needs all.
// - sync and pass events latch into read-clear flags.
`timescale 1ns/1ps
`include "tx_port_regs_consts.vh"
module tx_port_regs (
  input wire core_clk,
  input wire rst_n,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire tx_write_port,
  input wire tx_read_port,
  input wire sync_forwarding_enabled,
  input wire async_forwarding,
  input wire [3:0] rx_port_enabled,
  input wire [3:0] rx_port_valid,
  input wire tx_error,
  input wire streams_synced,
  input wire sync_fault,
  input wire rx_port_irq,
  input wire link_idle,
  input wire frame_end,
  output reg [7:0] reg_rdata_q,
  output reg cal_active_q,
  output reg cal_bit_q,
  output reg irq_q
);
  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam IN_W = 17;
  wire [IN_W-1:0] raw_in;
  reg [IN_W-1:0] meta_q;
  reg [IN_W-1:0] sync_q;
  assign raw_in = {tx_read_port, sync_forwarding_enabled, async_forwarding,
                   rx_port_enabled, rx_port_valid, tx_error, streams_synced,
                   sync_fault, rx_port_irq, link_idle, frame_end};
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 17'h00000;
      sync_q <= 17'h00000;
    end else begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end
  wire s_read_port = sync_q[16];
  wire s_sync_en = sync_q[15];
  wire s_async = sync_q[14];
  wire [3:0] s_en = sync_q[13:10];
  wire [3:0] s_valid = sync_q[9:6];
  wire s_err = sync_q[5];
  wire s_synced = sync_q[4];
  wire s_fault = sync_q[3];
  wire s_rx_irq = sync_q[2];
  wire s_idle = sync_q[1];
  wire s_fe = sync_q[0];

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  reg [7:0] ctl2_q;
  reg [4:0] ie_q;
  reg [4:0] isr_q;
  wire wr_ok = reg_wr & tx_write_port;
  wire wr_ctl2 = wr_ok & (reg_addr == `ADDR_TX_PORT_CONTROL_TWO);
  wire wr_ie = wr_ok & (reg_addr == `ADDR_TX_INTERRUPT_ENABLE);
  wire rd_isr = reg_rd & (reg_addr == `ADDR_TX_INTERRUPT_STATUS);
  wire cal_done;
  wire cal_busy;
  wire seq_bit;

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  wire [3:0] ok_ports = s_en & s_valid;
  wire any_ok = |ok_ports;
  wire all_ok = (s_en != 4'h0) & ((s_en & ~s_valid) == 4'h0);
  wire pass_sel = ctl2_q[`CTL2_PASS_MODE_BIT] ? all_ok : any_ok;
  // asynchronous: actively delivering, error drops it; synced: data available
  wire pass_d = s_async ? (pass_sel & ~s_err) : pass_sel;
  wire sync_d = s_sync_en & s_synced;
  reg pass_q;
  reg sync_flag_q;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pass_q <= 1'b0;
      sync_flag_q <= 1'b0;
    end else begin
      pass_q <= pass_d;
      sync_flag_q <= sync_d;
    end
  end

  // ----------------------------------------------------------------
  // calibration scheduling
  // ----------------------------------------------------------------
  reg single_pend_q;
  reg periodic_pend_q;
  reg single_run_q;
  wire start_ok = s_idle & ~cal_busy;
  wire start_single = single_pend_q & start_ok;
  wire start_per = periodic_pend_q & ~single_pend_q & start_ok;
  wire cal_start = start_single | start_per;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctl2_q <= `CTL2_RESET;
      single_pend_q <= 1'b0;
      periodic_pend_q <= 1'b0;
      single_run_q <= 1'b0;
    end else begin
      if (wr_ctl2) begin
        ctl2_q <= {4'h0, reg_wdata[3:2], reg_wdata[1] | ctl2_q[1], reg_wdata[0]};
        if (reg_wdata[`CTL2_CAL_SINGLE_BIT] & ~ctl2_q[`CTL2_CAL_SINGLE_BIT])
          single_pend_q <= 1'b1;
      end
      if (start_single) begin
        single_pend_q <= 1'b0;
        single_run_q <= 1'b1;
      end
      if (cal_done & single_run_q) begin
        single_run_q <= 1'b0;
        ctl2_q[`CTL2_CAL_SINGLE_BIT] <= 1'b0;
      end
      if (s_fe & ctl2_q[`CTL2_CAL_PERIODIC_BIT])
        periodic_pend_q <= 1'b1;
      else if (start_per | ~ctl2_q[`CTL2_CAL_PERIODIC_BIT])
        periodic_pend_q <= 1'b0;
    end
  end

  skew_cal_seq u_seq (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .start(cal_start),
    .invert(ctl2_q[`CTL2_CAL_INV_BIT]),
    .busy_q(cal_busy),
    .cal_bit_q(seq_bit),
    .done_q(cal_done)
  );
  reg seq_bit_d;
  always @* begin
    seq_bit_d = 1'b0;
    if (cal_busy)
      seq_bit_d = seq_bit;
  end

  // ----------------------------------------------------------------
  // interrupt enable and event flags
  // ----------------------------------------------------------------
  reg pass_prev_q;
  reg sync_prev_q;
  reg fault_prev_q;
  wire ev_pass = pass_q & ~pass_prev_q & ie_q[`IE_PASS_BIT];
  wire ev_pass_err = ~pass_q & pass_prev_q & ie_q[`IE_PASS_ERROR_BIT];
  wire ev_sync = sync_flag_q & ~sync_prev_q & ie_q[`IE_SYNC_BIT];
  wire ev_fault = s_fault & ~fault_prev_q & ie_q[`IE_SYNC_FAULT_BIT];
  wire [4:0] ev = {1'b0, ev_fault, ev_sync, ev_pass_err, ev_pass};
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ie_q <= 5'h00;
      isr_q <= 5'h00;
      pass_prev_q <= 1'b0;
      sync_prev_q <= 1'b0;
      fault_prev_q <= 1'b0;
    end else begin
      pass_prev_q <= pass_q;
      sync_prev_q <= sync_flag_q;
      fault_prev_q <= s_fault;
      if (wr_ie)
        ie_q <= reg_wdata[4:0];
      // set wins over read-clear
      isr_q[3:0] <= (rd_isr ? 4'h0 : isr_q[3:0]) | ev[3:0];
      isr_q[4] <= s_rx_irq & ie_q[`IE_RX_PORT_BIT];
    end
  end

  // ----------------------------------------------------------------
  // readback and outputs
  // ----------------------------------------------------------------
  reg [7:0] rdata_d;
  always @* begin
    case (reg_addr)
      `ADDR_TX_PORT_CONTROL_TWO: rdata_d = ctl2_q;
      `ADDR_TX_PORT_STATUS: rdata_d = {3'h0, s_read_port, 2'h0, sync_flag_q, pass_q};
      `ADDR_TX_INTERRUPT_ENABLE: rdata_d = {3'h0, ie_q};
      `ADDR_TX_INTERRUPT_STATUS: rdata_d = {3'h0, isr_q};
      default: rdata_d = 8'h00;
    endcase
  end
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_q <= 8'h00;
      cal_active_q <= 1'b0;
      cal_bit_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      if (reg_rd)
        reg_rdata_q <= rdata_d;
      cal_active_q <= cal_busy;
      cal_bit_q <= seq_bit_d;
      irq_q <= |isr_q;
    end
  end
endmodule // tx_port_regs

//--- hdl/tx_port_regs_consts.vh
// register offsets, field positions, reset values and timing counts
// assumes byte-wide register port on core_clk
`ifndef TX_PORT_REGS_CONSTS_VH
`define TX_PORT_REGS_CONSTS_VH
`define ADDR_TX_PORT_CONTROL_TWO 8'h34
`define ADDR_TX_PORT_STATUS 8'h35
`define ADDR_TX_INTERRUPT_ENABLE 8'h36
`define ADDR_TX_INTERRUPT_STATUS 8'h37
`define CTL2_PASS_MODE_BIT 3
`define CTL2_CAL_INV_BIT 2
`define CTL2_CAL_SINGLE_BIT 1
`define CTL2_CAL_PERIODIC_BIT 0
`define STS_PORT_NUM_BIT 4
`define STS_SYNC_BIT 1
`define STS_PASS_BIT 0
`define IE_RX_PORT_BIT 4
`define IE_SYNC_FAULT_BIT 3
`define IE_SYNC_BIT 2
`define IE_PASS_ERROR_BIT 1
`define IE_PASS_BIT 0
`define CTL2_RESET 8'h00
`define IE_RESET 8'h00
`define CAL_LEN_LOG2 10
`define CAL_LEN_BITS 11'h400
`endif
